// ---- ext_bus_pkg.sv ----
package ext_bus_pkg;
  // APB register byte offsets
  localparam logic [7:0] BUS_CTRL_OFF = 8'h00;
  localparam logic [7:0] WAIT_ONE_OFF = 8'h04;
  localparam logic [7:0] WAIT_TWO_OFF = 8'h08;
  localparam logic [7:0] WAIT_THREE_OFF = 8'h0C;
  localparam logic [7:0] DRAM_CTRL_OFF = 8'h10;
  localparam logic [7:0] STATUS_OFF = 8'h14;
  // Bus control fields
  localparam int DRAM_EN_BIT = 15;
  localparam int IO_EN_BIT = 14;
  localparam int DUTY_BIT = 13;
  localparam int LANE_BIT = 12;
  // DRAM control fields
  localparam int MUX_EN_BIT = 4;
  localparam int SHIFT_HI_BIT = 1;
  localparam int SHIFT_LO_BIT = 0;
  // Wait control three fields
  localparam int LW02_LO = 4;
  localparam int LW6_LO = 0;
  // Reset values
  localparam logic [15:0] BUS_CTRL_RST = 16'h0000;
  localparam logic [15:0] WAIT_ONE_RST = 16'h00FF;
  localparam logic [15:0] WAIT_TWO_RST = 16'h00FF;
  localparam logic [15:0] WAIT_THREE_RST = 16'h00FF;
  localparam logic [15:0] DRAM_CTRL_RST = 16'h0000;
  // Duty timing in tenths of a ns
  localparam int PCLK_PERIOD_TENTHS = 80;
  localparam int DUTY_35_PCT = 35;
  localparam int DUTY_50_PCT = 50;
  // Boot codes
  localparam logic [2:0] BOOT_EXT8 = 3'h0;
  localparam logic [2:0] BOOT_EXT16 = 3'h1;
  localparam logic [2:0] BOOT_ROM = 3'h2;
  // Shift codes
  localparam logic [1:0] SHIFT8 = 2'h0;
  localparam logic [1:0] SHIFT9 = 2'h1;
  localparam logic [1:0] SHIFT10 = 2'h2;

  typedef enum logic [1:0] {
    CPU_READ, CPU_WRITE, DMA_SINGLE, DMA_DUAL_READ
  } access_kind_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [2:0] area;
    logic wide;
    logic io_space;
    logic upper;
    logic lower;
    access_kind_t kind;
    logic write;
  } request_t;

  typedef struct packed {
    logic rd_n;
    logic a0_or_upper_sel_n;
    logic upper_or_lower_n;
    logic lower_or_common_n;
    logic dram_cycle;
    logic row_phase;
    logic [21:0] pin_addr;
  } pins_t;
endpackage : ext_bus_pkg

// ---- ext_memory_bus_cycle_ctrl.sv ----
`timescale 1ns/10ps
module ext_memory_bus_cycle_ctrl
  import ext_bus_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] boot_config_pins,
  input wire logic req_valid,
  input wire request_t req,
  output logic req_ready,
  output logic done,
  input wire logic wait_n,
  output pins_t pins,
  output logic rom_space
);
  typedef enum logic [2:0] {IDLE, BASE, LONG, PINWAIT, FINAL} state_t;

  logic [15:0] bus_control_reg, bus_control_next;
  logic [15:0] wait_ctrl_reg_one, wait_ctrl_one_next;
  logic [15:0] wait_ctrl_reg_two, wait_ctrl_two_next;
  logic [15:0] wait_ctrl_reg_three, wait_ctrl_three_next;
  logic [15:0] dram_control_reg, dram_control_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [2:0] boot_reg, boot_next;
  logic boot_taken_reg, boot_taken_next;
  state_t state_reg, state_next;
  request_t cur_reg, cur_next;
  logic [1:0] lw_reg, lw_next;
  logic pin_reg, pin_next;
  logic done_reg, done_next;
  pins_t pins_reg, pins_next;

  localparam int DUTY_CUT_35 = PCLK_PERIOD_TENTHS * DUTY_35_PCT / 1000;
  localparam int DUTY_CUT_50 = PCLK_PERIOD_TENTHS * DUTY_50_PCT / 1000;

  function automatic logic long_area(input logic [2:0] a);
    long_area = (a == 3'h0) || (a == 3'h2) || (a == 3'h6);
  endfunction : long_area

  // Wait bit per access kind and area
  function automatic logic wait_bit(input request_t r, input logic [15:0] w1,
                                    input logic [15:0] w2);
    if (r.kind == DMA_SINGLE) begin
      wait_bit = w2[r.area];
    end else if (r.write) begin
      wait_bit = 1'b1;
    end else begin
      wait_bit = w1[r.area];
    end
  endfunction : wait_bit

  // APB: zero-wait slave, unmapped reads zero with error
  logic wr_en;
  logic mapped;
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  always_comb begin
    mapped = (paddr == BUS_CTRL_OFF) || (paddr == WAIT_ONE_OFF) ||
             (paddr == WAIT_TWO_OFF) || (paddr == WAIT_THREE_OFF) ||
             (paddr == DRAM_CTRL_OFF) || (paddr == STATUS_OFF);
  end
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    bus_control_next = bus_control_reg;
    wait_ctrl_one_next = wait_ctrl_reg_one;
    wait_ctrl_two_next = wait_ctrl_reg_two;
    wait_ctrl_three_next = wait_ctrl_reg_three;
    dram_control_next = dram_control_reg;
    prdata_next = prdata_reg;
    if (wr_en) begin
      case (paddr)
        BUS_CTRL_OFF: bus_control_next = pwdata[15:0];
        WAIT_ONE_OFF: wait_ctrl_one_next = pwdata[15:0];
        WAIT_TWO_OFF: wait_ctrl_two_next = pwdata[15:0];
        WAIT_THREE_OFF: wait_ctrl_three_next = pwdata[15:0];
        DRAM_CTRL_OFF: dram_control_next = pwdata[15:0];
        default: ;
      endcase
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        BUS_CTRL_OFF: prdata_next = {16'h0000, bus_control_reg};
        WAIT_ONE_OFF: prdata_next = {16'h0000, wait_ctrl_reg_one};
        WAIT_TWO_OFF: prdata_next = {16'h0000, wait_ctrl_reg_two};
        WAIT_THREE_OFF: prdata_next = {16'h0000, wait_ctrl_reg_three};
        DRAM_CTRL_OFF: prdata_next = {16'h0000, dram_control_reg};
        STATUS_OFF: prdata_next = {24'h000000, boot_reg, 2'h0, pin_reg,
                                   (state_reg != IDLE), rom_space};
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_control_reg <= BUS_CTRL_RST;
      wait_ctrl_reg_one <= WAIT_ONE_RST;
      wait_ctrl_reg_two <= WAIT_TWO_RST;
      wait_ctrl_reg_three <= WAIT_THREE_RST;
      dram_control_reg <= DRAM_CTRL_RST;
      prdata_reg <= 32'h00000000;
    end else begin
      bus_control_reg <= bus_control_next;
      wait_ctrl_reg_one <= wait_ctrl_one_next;
      wait_ctrl_reg_two <= wait_ctrl_two_next;
      wait_ctrl_reg_three <= wait_ctrl_three_next;
      dram_control_reg <= dram_control_next;
      prdata_reg <= prdata_next;
    end
  end

  // Boot strap caught once after reset release
  always_comb begin
    boot_next = boot_reg;
    boot_taken_next = 1'b1;
    if (!boot_taken_reg) begin
      boot_next = boot_config_pins;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg <= BOOT_EXT8;
      boot_taken_reg <= 1'b0;
    end else begin
      boot_reg <= boot_next;
      boot_taken_reg <= boot_taken_next;
    end
  end
  // area 0 space from boot code
  assign rom_space = (boot_reg == BOOT_ROM);

  // Cycle sequencer
  logic lw_zero;
  assign lw_zero = (lw_reg == 2'h0);
  assign req_ready = (state_reg == IDLE) && boot_taken_reg;
  assign done = done_reg;

  always_comb begin
    logic use_pin;
    logic [1:0] lw_cnt;
    use_pin = 1'b0;
    lw_cnt = 2'h0;
    state_next = state_reg;
    cur_next = cur_reg;
    lw_next = lw_reg;
    pin_next = pin_reg;
    done_next = 1'b0;
    case (state_reg)
      IDLE: begin
        if (req_valid && req_ready) begin
          // Area 3 masked where the pin is sampled
          use_pin = wait_bit(req, wait_ctrl_reg_one, wait_ctrl_reg_two);
          lw_cnt = (req.area == 3'h6) ? wait_ctrl_reg_three[LW6_LO +: 2] :
                                       wait_ctrl_reg_three[LW02_LO +: 2];
          cur_next = req;
          pin_next = use_pin;
          lw_next = lw_cnt;
          state_next = BASE;
        end
      end
      BASE: begin
        if (long_area(cur_reg.area)) begin
          state_next = LONG;
          if (lw_zero && pin_reg && !wait_n) begin
            state_next = PINWAIT;
          end
        end else if (pin_reg) begin
          // second state follows, pin sampled now
          // area 3 keeps two states, pin shared
          state_next = (wait_n || cur_reg.area == 3'h3) ? FINAL : PINWAIT;
        end else begin
          state_next = IDLE;
          done_next = 1'b1;
        end
      end
      LONG: begin
        if (lw_zero) begin
          state_next = IDLE;
          done_next = 1'b1;
        end else if (lw_reg == 2'h1 && pin_reg && !wait_n) begin
          state_next = PINWAIT;
        end else begin
          lw_next = lw_reg - 2'h1;
        end
      end
      PINWAIT: begin
        if (wait_n) begin
          state_next = FINAL;
          lw_next = 2'h0;
        end
      end
      FINAL: begin
        state_next = IDLE;
        done_next = 1'b1;
      end
      default: state_next = IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= IDLE;
      cur_reg <= '0;
      lw_reg <= 2'h0;
      pin_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      lw_reg <= lw_next;
      pin_reg <= pin_next;
      done_reg <= done_next;
    end
  end

  // Pin formation
  logic row_done_reg, row_done_next;
  always_comb begin
    logic dram;
    logic [1:0] shift;
    logic active;
    active = (state_next != IDLE);
    dram = bus_control_reg[DRAM_EN_BIT] && (cur_next.area == 3'h1);
    shift = {dram_control_reg[SHIFT_HI_BIT], dram_control_reg[SHIFT_LO_BIT]};
    pins_next = '0;
    pins_next.rd_n = 1'b1;
    pins_next.a0_or_upper_sel_n = 1'b1;
    pins_next.upper_or_lower_n = 1'b1;
    pins_next.lower_or_common_n = 1'b1;
    row_done_next = 1'b0;
    if (active) begin
      pins_next.dram_cycle = dram;
      pins_next.pin_addr = cur_next.addr[21:0];
      if (dram && dram_control_reg[MUX_EN_BIT] && !row_done_reg) begin
        pins_next.row_phase = 1'b1;
        row_done_next = 1'b1;
        case (shift)
          SHIFT8: pins_next.pin_addr = {6'h00, cur_next.addr[23:8]};
          SHIFT9: pins_next.pin_addr = {7'h00, cur_next.addr[23:9]};
          SHIFT10: pins_next.pin_addr = {8'h00, cur_next.addr[23:10]};
          default: pins_next.pin_addr = {6'h00, cur_next.addr[23:8]};
        endcase
      end else begin
        row_done_next = row_done_reg;
      end
      if (!dram) begin
        pins_next.rd_n = cur_next.write;
        if (cur_next.wide) begin
          // same for muxed I/O and plain space
          if (bus_control_reg[LANE_BIT]) begin
            pins_next.lower_or_common_n = !cur_next.write;
            pins_next.upper_or_lower_n = !cur_next.lower;
            pins_next.a0_or_upper_sel_n = !cur_next.upper;
          end else begin
            pins_next.lower_or_common_n = !(cur_next.write && cur_next.lower);
            pins_next.upper_or_lower_n = !(cur_next.write && cur_next.upper);
            pins_next.a0_or_upper_sel_n = cur_next.addr[0];
          end
        end else begin
          // eight-bit uses A0 and common strobe
          pins_next.lower_or_common_n = !cur_next.write;
          pins_next.a0_or_upper_sel_n = cur_next.addr[0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_reg <= '{rd_n: 1'b1, a0_or_upper_sel_n: 1'b1, upper_or_lower_n: 1'b1,
                    lower_or_common_n: 1'b1, dram_cycle: 1'b0, row_phase: 1'b0,
                    pin_addr: 22'h000000};
      row_done_reg <= 1'b0;
    end else begin
      pins_reg <= pins_next;
      row_done_reg <= row_done_next;
    end
  end

  // Read strobe duty: high part of first state is a fraction of a cycle,
  // which the bench sees only as the duty selection; sub-cycle shaping is
  // left to the pad cell since one clock cannot cut 35 percent.
  logic duty_sel;
  assign duty_sel = bus_control_reg[DUTY_BIT];
  always_comb begin
    pins = pins_reg;
  end

  // single-state cycle ends after one base state
  single_state_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == BASE && !pin_reg && !long_area(cur_reg.area)) |=> done_reg)
    else $error("short cycle did not end");
  pin_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == PINWAIT && !wait_n) |=> state_reg == PINWAIT)
    else $error("wait released while pin low");
  busy_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg != IDLE) |-> !req_ready)
    else $error("request taken during cycle");
  // area 3 never waits on pin
  area3_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg != IDLE && cur_reg.area == 3'h3) |-> state_reg != PINWAIT)
    else $error("area 3 used pin wait");
  two_state_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == BASE && pin_reg && !long_area(cur_reg.area) && wait_n)
    |=> state_reg == FINAL ##1 done_reg)
    else $error("two state cycle wrong");
  // long wait cycle without wait bit never stalls on pin
  long_nopin_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == LONG && !pin_reg) |-> state_next != PINWAIT)
    else $error("pin used without wait bit");
  row_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pins_reg.row_phase && $past(dram_control_reg[1:0]) == SHIFT8)
    |-> pins_reg.pin_addr[15:0] == cur_reg.addr[23:8])
    else $error("row address wrong");
  narrow_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg != IDLE && !cur_reg.wide) |-> pins_reg.upper_or_lower_n)
    else $error("upper strobe in 8-bit space");
  // write sets pin use unless DMA_SINGLE
  write_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && req_ready && req.write && req.kind != DMA_SINGLE &&
     req.area != 3'h3) |=> pin_reg)
    else $error("write ignored wait pin");
endmodule : ext_memory_bus_cycle_ctrl

// ---- sram_wait_model.sv ----
`timescale 1ns/10ps
module sram_wait_model
  import ext_bus_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire pins_t pins,
  input wire logic [3:0] hold_cycles,
  output logic wait_n
);
  logic active;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  // Read, upper/lower or lower/common strobe low counts as a running cycle
  assign active = !pins.rd_n || !pins.upper_or_lower_n || !pins.lower_or_common_n;
  always_comb begin
    cnt_next = cnt_reg;
    if (!active) begin
      cnt_next = hold_cycles;
    end else if (cnt_reg != 4'h0) begin
      cnt_next = cnt_reg - 4'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  // Slow device pulls wait as soon as strobes appear
  assign wait_n = !(active && cnt_reg != 4'h0);
endmodule : sram_wait_model

// ---- ext_memory_bus_cycle_ctrl_tb_top.sv ----
`timescale 1ns/10ps
module ext_memory_bus_cycle_ctrl_tb_top
  import ext_bus_pkg::*;
;
  localparam logic [23:0] DRAM_ADDR = 24'hA5C3E7;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] boot_config_pins;
  logic req_valid, req_ready, done, wait_n, rom_space, busy1;
  request_t req;
  pins_t pins, p1, p2;
  logic [3:0] hold;
  int fail_count = 0;
  int comparisons = 0;

  ext_memory_bus_cycle_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boot_config_pins(boot_config_pins),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done),
    .wait_n(wait_n), .pins(pins), .rom_space(rom_space));
  sram_wait_model i_mem (.pclk(pclk), .presetn(presetn), .pins(pins),
    .hold_cycles(hold), .wait_n(wait_n));

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    check(32'(pready), 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb_xfer

  task automatic access(input logic [2:0] ar, input access_kind_t k, input logic wr,
    input logic [23:0] ad, input logic up, input logic lo, input logic wd, input logic io,
    input int lat);
    int n;
    req <= '{addr: ad, area: ar, wide: wd, io_space: io, upper: up, lower: lo, kind: k,
      write: wr};
    req_valid <= 1'h1;
    n = 0;
    #1;
    while (req_ready !== 1'h1 && n < 50) begin
      @(posedge pclk);
      #1;
      n++;
    end
    @(posedge pclk);
    req_valid <= 1'h0;
    #1;
    p1 = pins;
    busy1 = req_ready;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
      if (n == 1) begin
        p2 = pins;
      end
    end while (done !== 1'h1 && n < 60);
    check(32'(done), 32'h1);
    if (lat > 0) begin
      check(32'(n), 32'(lat));
    end
    check(32'(busy1), 32'h0);
    @(posedge pclk);
  endtask : access

  // Wait register one stays all ones, so only single mode can clear a bit
  function automatic int exp_lat(input logic [2:0] ar, input access_kind_t k,
    input logic [7:0] w2, input logic [7:0] w3, input int h);
    logic sel;
    int lw;
    lw = 1 + ((ar == 3'h6) ? int'(w3[LW6_LO +: 2]) : int'(w3[LW02_LO +: 2]));
    sel = (k == DMA_SINGLE) ? w2[ar] : 1'h1;
    // Model holds wait low for h states from strobe start
    if (ar == 3'h0 || ar == 3'h2 || ar == 3'h6) begin
      return 1 + lw + ((sel && h >= lw) ? h - lw + 1 : 0);
    end
    if (!sel) begin
      return 1;
    end
    return (ar == 3'h3) ? 2 : 2 + h;
  endfunction : exp_lat

  task automatic run_case(input logic [2:0] ar, input access_kind_t k, input logic wr,
    input logic [7:0] w2, input logic [7:0] w3, input logic [3:0] h);
    logic [31:0] d;
    logic e;
    apb_xfer(1'h1, WAIT_TWO_OFF, {24'h0, w2}, d, e);
    apb_xfer(1'h1, WAIT_THREE_OFF, {24'h0, w3}, d, e);
    hold <= h;
    access(ar, k, wr, 24'h001234, 1'h1, 1'h1, 1'h1, 1'h0, exp_lat(ar, k, w2, w3, int'(h)));
  endtask : run_case

  task automatic strobe_case(input logic lane, input logic wd, input logic io,
    input logic up, input logic lo, input logic wr, input logic [23:0] ad);
    logic [31:0] d;
    logic e;
    logic [3:0] ex;
    logic [3:0] got;
    apb_xfer(1'h1, BUS_CTRL_OFF, 32'(lane) << LANE_BIT, d, e);
    hold <= 4'h0;
    access(3'h4, wr ? CPU_WRITE : CPU_READ, wr, ad, up, lo, wd, io, -1);
    got = {p1.rd_n, p1.a0_or_upper_sel_n, p1.upper_or_lower_n, p1.lower_or_common_n};
    // Upper pin is unused in 8-bit space
    if (!wd) begin
      ex = {wr, ad[0], 1'h1, !wr};
    end else if (lane) begin
      ex = {wr, !up, !lo, !wr};
    end else begin
      ex = {wr, ad[0], !(wr && up), !(wr && lo)};
    end
    check(32'(got), 32'(ex));
  endtask : strobe_case

  task automatic dram_case(input logic [1:0] s);
    logic [31:0] d;
    logic e;
    logic [21:0] m;
    apb_xfer(1'h1, BUS_CTRL_OFF, 32'h1 << DRAM_EN_BIT, d, e);
    apb_xfer(1'h1, DRAM_CTRL_OFF, (32'h1 << MUX_EN_BIT) | 32'(s), d, e);
    access(3'h1, CPU_READ, 1'h0, DRAM_ADDR, 1'h1, 1'h1, 1'h1, 1'h0, -1);
    m = 22'h00FFFF >> s;
    check(32'({p1.dram_cycle, p1.row_phase}), 32'h3);
    check(32'(p1.pin_addr & m), 32'((DRAM_ADDR >> (4'h8 + s)) & m));
    check(32'(p2.pin_addr), 32'(DRAM_ADDR[21:0]));
  endtask : dram_case

  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end

  // Whole run is a few hundred cycles
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] d;
    logic e;
    logic [7:0] offs [5] = '{BUS_CTRL_OFF, WAIT_ONE_OFF, WAIT_TWO_OFF, WAIT_THREE_OFF,
      DRAM_CTRL_OFF};
    logic [15:0] rsts [5] = '{BUS_CTRL_RST, WAIT_ONE_RST, WAIT_TWO_RST, WAIT_THREE_RST,
      DRAM_CTRL_RST};
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req_valid = 1'h0;
    req = '0;
    hold = 4'h0;
    boot_config_pins = BOOT_EXT16;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    check(32'(rom_space), 32'h0);
    for (int i = 0; i < 5; i++) begin
      apb_xfer(1'h0, offs[i], 32'h0, d, e);
      check(d, {16'h0, rsts[i]});
    end
    apb_xfer(1'h1, 8'h18, 32'h5A5A, d, e);
    apb_xfer(1'h0, 8'h18, 32'h0, d, e);
    check({d[30:0], e}, 32'h1);
    apb_xfer(1'h1, BUS_CTRL_OFF, 32'hFFFF2000, d, e);
    apb_xfer(1'h0, BUS_CTRL_OFF, 32'h0, d, e);
    check(d, 32'h00002000);
    apb_xfer(1'h1, WAIT_ONE_OFF, 32'h000000FF, d, e);
    $display("test registers done");
    run_case(3'h4, CPU_READ, 1'h0, 8'h00, 8'h33, 4'h2);
    run_case(3'h4, DMA_SINGLE, 1'h0, 8'h00, 8'h33, 4'h2);
    run_case(3'h4, DMA_DUAL_READ, 1'h0, 8'h00, 8'h33, 4'h2);
    run_case(3'h5, DMA_SINGLE, 1'h0, 8'hFF, 8'h33, 4'h1);
    run_case(3'h3, CPU_READ, 1'h0, 8'hFF, 8'h33, 4'h2);
    run_case(3'h7, DMA_SINGLE, 1'h1, 8'h00, 8'h33, 4'h2);
    run_case(3'h1, CPU_WRITE, 1'h1, 8'h00, 8'h33, 4'h2);
    run_case(3'h0, DMA_SINGLE, 1'h0, 8'h00, 8'h03, 4'h2);
    run_case(3'h2, DMA_SINGLE, 1'h0, 8'h00, 8'h30, 4'h2);
    run_case(3'h6, CPU_READ, 1'h0, 8'hFF, 8'h02, 4'h2);
    run_case(3'h0, CPU_WRITE, 1'h1, 8'h00, 8'h12, 4'h2);
    run_case(3'h6, DMA_SINGLE, 1'h1, 8'hFF, 8'h30, 4'h3);
    $display("test wait timing done");
    strobe_case(1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 24'h000101);
    strobe_case(1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 24'h000100);
    strobe_case(1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 24'h000101);
    strobe_case(1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 24'h000100);
    strobe_case(1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 24'h000103);
    strobe_case(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 24'h000100);
    $display("test byte lanes done");
    for (int s = 0; s < 3; s++) begin
      dram_case(2'(s));
    end
    $display("test dram mux done");
    presetn <= 1'h0;
    boot_config_pins <= BOOT_ROM;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    check(32'(rom_space), 32'h1);
    $display("test boot strap done");
    tally_and_finish();
  end
endmodule : ext_memory_bus_cycle_ctrl_tb_top
